/* verilog/fpc_pkg.sv */
// Constants, types and the behaviour summary of the dual fast pulse counter.
// How it works
// - Two counters run side by side, each with its own accumulator and its own configuration.
// - Each counter works in exactly one of five modes: totalize, frequency, pulse width, period or quadrature.
// - Four dedicated pulse inputs exist and each counter selects which of them feed its functions.
// - Up/down, clock/direction and quadrature use two of the four inputs for one counter.
// - Clear forces the accumulator to zero, but does nothing in frequency or period mode.
// - While disable is active the accumulator does not advance.
// - An active latch strobe copies the accumulator to the latch register at once or on release.
// - A preload event loads the preload value unless a clear fires with it, and does nothing in frequency or period mode.
// - Every trigger has its own polarity: high level, low level, falling edge or rising edge.
// - Totalize counts up or down, as its sub-mode selects, once per cycle with a rising edge, up/down not when both rise; clk/dir counts input 1 edges only.
// - Quadrature counts every edge of both phases, four counts per input cycle.
`default_nettype none
package fpc_pkg;
  // ---------------------------------------------------------------
  // Sizes and timing
  // ---------------------------------------------------------------
  localparam int          FPC_NUM_CNT   = 2;
  localparam int          FPC_NUM_IN    = 4;
  localparam int          FPC_ACC_W     = 32;
  localparam int          FPC_CLK_MHZ   = 125;
  localparam int          FPC_TICK_US   = 1;
  localparam int          FPC_TICK_CYC  = FPC_CLK_MHZ * FPC_TICK_US;
  localparam int          FPC_WIN_MS    = 1000;
  localparam int          FPC_WIN_TICKS = FPC_WIN_MS * 1000;
  localparam logic [31:0] FPC_ACC_ZERO  = 32'h0000_0000;
  localparam logic [31:0] FPC_ACC_ONE   = 32'h0000_0001;
  localparam logic [31:0] FPC_ACC_FOUR  = 32'h0000_0004;

  // ---------------------------------------------------------------
  // Modes and sub-modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FPC_MODE_TOTAL = 3'h0,
    FPC_MODE_FREQ  = 3'h1,
    FPC_MODE_WIDTH = 3'h2,
    FPC_MODE_PER   = 3'h3,
    FPC_MODE_QUAD  = 3'h4
  } fpc_mode_e;

  // Totalize: 0 up, 1 down, 2 up/down, 3 clk/dir. Width: 0 high, 1 low.
  // Period: 0 rising, 1 falling. Quad: 0 input 1 leads counts up, 1 down.
  localparam logic [1:0] FPC_SUB_A = 2'h0;
  localparam logic [1:0] FPC_SUB_B = 2'h1;
  localparam logic [1:0] FPC_SUB_C = 2'h2;
  localparam logic [1:0] FPC_SUB_D = 2'h3;

  typedef enum logic [1:0] {
    FPC_POL_HIGH = 2'h0,
    FPC_POL_LOW  = 2'h1,
    FPC_POL_FALL = 2'h2,
    FPC_POL_RISE = 2'h3
  } fpc_pol_e;

  typedef struct packed {
    logic        en;
    logic [1:0]  sel;
    fpc_pol_e    pol;
  } fpc_trig_s;

  typedef struct packed {
    fpc_mode_e   mode;
    logic [1:0]  sub;
    logic [1:0]  in1_sel;
    logic [1:0]  in2_sel;
    logic        in2_en;
    logic        latch_on_release;
    fpc_trig_s   clr;
    fpc_trig_s   dis;
    fpc_trig_s   lat;
    fpc_trig_s   pre;
    logic [31:0] preload;
  } fpc_cfg_s;
endpackage
`default_nettype wire

/* verilog/fpc_dual_counter.sv */
// Dual fast pulse counter with five modes and special functions.
`default_nettype none
module fpc_dual_counter
  import fpc_pkg::*;
#(
  parameter int P_WIN_TICKS = FPC_WIN_TICKS
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_n,
  input  wire logic [FPC_NUM_IN-1:0]  i_pulse,
  input  wire fpc_cfg_s               i_cfg_0,
  input  wire fpc_cfg_s               i_cfg_1,
  output logic      [FPC_ACC_W-1:0]   o_acc_0,
  output logic      [FPC_ACC_W-1:0]   o_acc_1,
  output logic      [FPC_ACC_W-1:0]   o_latch_0,
  output logic      [FPC_ACC_W-1:0]   o_latch_1
);
  // ---------------------------------------------------------------
  // Trigger evaluation
  // ---------------------------------------------------------------
  function automatic logic trig_fire(input fpc_trig_s t, input logic [3:0] lvl,
                                     input logic [3:0] prv);
    logic a;
    logic b;
    a = lvl[t.sel];
    b = prv[t.sel];
    unique case (t.pol)
      FPC_POL_HIGH: trig_fire = t.en & a;
      FPC_POL_LOW:  trig_fire = t.en & ~a;
      FPC_POL_FALL: trig_fire = t.en & b & ~a;
      FPC_POL_RISE: trig_fire = t.en & ~b & a;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Input synchroniser and shared 1 us tick
  // ---------------------------------------------------------------
  localparam int TICK_W = 8;
  localparam int WIN_W  = 24;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(FPC_TICK_CYC - 1);
  localparam logic [WIN_W-1:0]  WIN_LAST  = WIN_W'(P_WIN_TICKS - 1);

  logic [FPC_NUM_IN-1:0] meta_r;
  logic [FPC_NUM_IN-1:0] sync_r;
  logic [FPC_NUM_IN-1:0] prev_r;
  logic [TICK_W-1:0]     tick_cnt_r;
  logic                  tick;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= i_pulse;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_r <= '0;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end
  assign tick = (tick_cnt_r == TICK_LAST);

  // ---------------------------------------------------------------
  // Counter channels
  // ---------------------------------------------------------------
  logic [FPC_ACC_W-1:0] acc_q [FPC_NUM_CNT];
  logic [FPC_ACC_W-1:0] lat_q [FPC_NUM_CNT];

  for (genvar c = 0; c < FPC_NUM_CNT; c++) begin : g_ch
    fpc_cfg_s             cfg;
    logic [FPC_ACC_W-1:0] acc_r;
    logic [FPC_ACC_W-1:0] acc_nxt;
    logic [FPC_ACC_W-1:0] lat_r;
    logic [FPC_ACC_W-1:0] run_r;
    logic [WIN_W-1:0]     win_r;
    logic                 lat_act_r;
    logic                 a_lvl, a_prv, b_lvl, b_prv, a_rise, a_fall, b_rise, b_fall;
    logic                 clr, dis, lat, pre, cnt_ok;

    assign cfg = (c == 0) ? i_cfg_0 : i_cfg_1;
    assign a_lvl  = sync_r[cfg.in1_sel];
    assign a_prv  = prev_r[cfg.in1_sel];
    // second input consumed by two-input modes
    assign b_lvl  = cfg.in2_en & sync_r[cfg.in2_sel];
    assign b_prv  = cfg.in2_en & prev_r[cfg.in2_sel];
    assign a_rise = a_lvl & ~a_prv;
    assign a_fall = ~a_lvl & a_prv;
    assign b_rise = b_lvl & ~b_prv;
    assign b_fall = ~b_lvl & b_prv;
    assign cnt_ok = (cfg.mode != FPC_MODE_FREQ) && (cfg.mode != FPC_MODE_PER);
    assign clr = cnt_ok & trig_fire(cfg.clr, sync_r, prev_r);
    assign dis = trig_fire(cfg.dis, sync_r, prev_r);
    assign lat = trig_fire(cfg.lat, sync_r, prev_r);
    assign pre = cnt_ok & trig_fire(cfg.pre, sync_r, prev_r);

    always_comb begin
      acc_nxt = acc_r;
      unique case (cfg.mode)
        FPC_MODE_TOTAL: begin
          unique case (cfg.sub)
            FPC_SUB_A: if (a_rise | b_rise) acc_nxt = acc_r + FPC_ACC_ONE;
            FPC_SUB_B: if (a_rise | b_rise) acc_nxt = acc_r - FPC_ACC_ONE;
            FPC_SUB_C: begin
              if (a_rise & ~b_rise) acc_nxt = acc_r + FPC_ACC_ONE;
              if (b_rise & ~a_rise) acc_nxt = acc_r - FPC_ACC_ONE;
            end
            FPC_SUB_D: begin
              if (a_rise) acc_nxt = b_lvl ? acc_r - FPC_ACC_ONE : acc_r + FPC_ACC_ONE;
            end
          endcase
        end
        FPC_MODE_QUAD: begin
          if ((a_rise & ~b_lvl) | (a_lvl & b_rise) | (a_fall & b_lvl) | (~a_lvl & b_fall))
            acc_nxt = (cfg.sub == FPC_SUB_A) ? acc_r + FPC_ACC_ONE : acc_r - FPC_ACC_ONE;
          else if ((b_rise & ~a_lvl) | (b_lvl & a_rise) | (b_fall & a_lvl) | (~b_lvl & a_fall))
            acc_nxt = (cfg.sub == FPC_SUB_A) ? acc_r - FPC_ACC_ONE : acc_r + FPC_ACC_ONE;
        end
        FPC_MODE_WIDTH: begin
          if ((cfg.sub == FPC_SUB_A) ? a_fall : a_rise) acc_nxt = run_r;
        end
        FPC_MODE_PER: begin
          if ((cfg.sub == FPC_SUB_A) ? a_rise : a_fall) acc_nxt = run_r;
        end
        FPC_MODE_FREQ: begin
          if (tick && win_r == WIN_LAST) acc_nxt = run_r;
        end
        default: acc_nxt = acc_r;
      endcase
    end

    // Width and period reuse run_r as a microsecond counter; frequency as an edge count.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        run_r <= '0;
      end else if (cfg.mode == FPC_MODE_FREQ) begin
        if (tick && win_r == WIN_LAST) run_r <= a_rise ? FPC_ACC_ONE : FPC_ACC_ZERO;
        else if (a_rise) run_r <= run_r + FPC_ACC_ONE;
      end else if (cfg.mode == FPC_MODE_WIDTH) begin
        if ((cfg.sub == FPC_SUB_A) ? a_rise : a_fall) run_r <= FPC_ACC_ZERO;
        else if (tick) run_r <= run_r + FPC_ACC_ONE;
      end else if (cfg.mode == FPC_MODE_PER) begin
        if ((cfg.sub == FPC_SUB_A) ? a_rise : a_fall) run_r <= FPC_ACC_ZERO;
        else if (tick) run_r <= run_r + FPC_ACC_ONE;
      end else begin
        run_r <= FPC_ACC_ZERO;
      end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        win_r <= '0;
      end else if (cfg.mode != FPC_MODE_FREQ) begin
        win_r <= '0;
      end else if (tick) begin
        win_r <= (win_r == WIN_LAST) ? '0 : win_r + 1'b1;
      end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        acc_r <= FPC_ACC_ZERO;
      end else if (clr) begin
        acc_r <= FPC_ACC_ZERO;
      end else if (pre) begin
        acc_r <= cfg.preload;
      end else if (!dis) begin
        acc_r <= acc_nxt;
      end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        lat_r     <= FPC_ACC_ZERO;
        lat_act_r <= 1'b0;
      end else begin
        lat_act_r <= lat;
        if (!cfg.latch_on_release && lat && !lat_act_r) lat_r <= acc_r;
        if (cfg.latch_on_release && !lat && lat_act_r) lat_r <= acc_r;
      end
    end

    assign acc_q[c] = acc_r;
    assign lat_q[c] = lat_r;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Outputs are copies of the channel flip-flops, adding one cycle of delay.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_acc_0   <= FPC_ACC_ZERO;
      o_acc_1   <= FPC_ACC_ZERO;
      o_latch_0 <= FPC_ACC_ZERO;
      o_latch_1 <= FPC_ACC_ZERO;
    end else begin
      o_acc_0   <= acc_q[0];
      o_acc_1   <= acc_q[1];
      o_latch_0 <= lat_q[0];
      o_latch_1 <= lat_q[1];
    end
  end
endmodule
`default_nettype wire

/* testbench/fpc_dual_counter_chk.sv */
// Port-level assertions for the dual fast pulse counter.
`default_nettype none
module fpc_dual_counter_chk
  import fpc_pkg::*;
#(
  parameter int P_WIN_TICKS = FPC_WIN_TICKS
) (
  input wire logic                  i_sys_clk,
  input wire logic                  i_rst_n,
  input wire logic [FPC_NUM_IN-1:0] i_pulse,
  input wire fpc_cfg_s              i_cfg_0,
  input wire fpc_cfg_s              i_cfg_1,
  input wire logic [FPC_ACC_W-1:0]  o_acc_0,
  input wire logic [FPC_ACC_W-1:0]  o_acc_1,
  input wire logic [FPC_ACC_W-1:0]  o_latch_0,
  input wire logic [FPC_ACC_W-1:0]  o_latch_1
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Level windows are wide so either pipeline depth of the pins is covered.
  wire logic clr1 = i_pulse[i_cfg_1.clr.sel];
  wire logic dis1 = i_pulse[i_cfg_1.dis.sel];
  a_reset_zero : assert property (
    $rose(i_rst_n) |-> (o_acc_0 | o_acc_1 | o_latch_0 | o_latch_1) == '0)
    else $error("outputs not zero after reset");
  a_tot_up_step : assert property (
    i_cfg_0.mode == FPC_MODE_TOTAL && i_cfg_0.sub == FPC_SUB_A |=>
    o_acc_0 - $past(o_acc_0) <= 1 || (i_cfg_0.clr.en && o_acc_0 == '0) ||
    (i_cfg_0.pre.en && o_acc_0 == i_cfg_0.preload))
    else $error("count up moved by more than one");
  a_tot_down_step : assert property (
    i_cfg_1.mode == FPC_MODE_TOTAL && i_cfg_1.sub == FPC_SUB_B |=>
    $past(o_acc_1) - o_acc_1 <= 1)
    else $error("count down moved by more than one");
  a_quad_step : assert property (
    i_cfg_1.mode == FPC_MODE_QUAD |=>
    o_acc_1 - $past(o_acc_1) <= 1 || $past(o_acc_1) - o_acc_1 == 1)
    else $error("quadrature moved by more than one");
  a_clear_zero : assert property (
    (clr1 && i_cfg_1.clr.en && i_cfg_1.clr.pol == FPC_POL_HIGH &&
    i_cfg_1.mode != FPC_MODE_FREQ && i_cfg_1.mode != FPC_MODE_PER)[*4] ##3 1
    |-> o_acc_1 == '0)
    else $error("held clear did not zero the count");
  a_disable_hold : assert property (
    (!dis1 && i_cfg_1.dis.en && i_cfg_1.dis.pol == FPC_POL_LOW &&
    !i_cfg_1.clr.en && !i_cfg_1.pre.en)[*5] ##2 1 |-> $stable(o_acc_1))
    else $error("disabled counter advanced");
  a_latch_copy : assert property (
    o_latch_0 != $past(o_latch_0) |-> i_cfg_0.lat.en && (o_latch_0 == o_acc_0 ||
    o_latch_0 == $past(o_acc_0) || o_latch_0 == $past(o_acc_0, 2)))
    else $error("latch took a value not from the count");
  a_latch_idle : assert property (
    !i_cfg_1.lat.en |=> $stable(o_latch_1))
    else $error("latch changed without strobe");
endmodule
bind fpc_dual_counter fpc_dual_counter_chk #(.P_WIN_TICKS(P_WIN_TICKS)) chk_u (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_pulse(i_pulse), .i_cfg_0(i_cfg_0),
  .i_cfg_1(i_cfg_1), .o_acc_0(o_acc_0), .o_acc_1(o_acc_1), .o_latch_0(o_latch_0),
  .o_latch_1(o_latch_1));
`default_nettype wire

/* testbench/fpc_pulse_src.sv */
// Pulse and encoder source model for the four counter pins.
`default_nettype none
module fpc_pulse_src
  import fpc_pkg::*;
(
  input  wire logic                  i_sys_clk,
  output logic      [FPC_NUM_IN-1:0] o_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_pulse = '0;
  end
  task automatic set(input int idx, input logic v);
    @(negedge i_sys_clk);
    o_pulse[idx] = v;
  endtask
  // A slow source is just a longer hold; pulses under one clock may be lost.
  task automatic pulse(input int idx, input int n, input int hold);
    repeat (n) begin
      set(idx, 1'b1);
      repeat (hold - 1) @(negedge i_sys_clk);
      set(idx, 1'b0);
      repeat (hold - 1) @(negedge i_sys_clk);
    end
  endtask
  task automatic quad(input int steps, input logic up);
    repeat (steps) begin
      @(negedge i_sys_clk);
      o_pulse[3:2] = up ? {o_pulse[2], ~o_pulse[3]} : {~o_pulse[2], o_pulse[3]};
      repeat (7) @(negedge i_sys_clk);
    end
  endtask
endmodule
`default_nettype wire

/* testbench/fpc_dual_counter_test.sv */
// Directed tests of the dual fast pulse counter.
`default_nettype none
module fpc_dual_counter_test
  import fpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [FPC_NUM_IN-1:0] pulse;
  fpc_cfg_s              c0 = '0;
  fpc_cfg_s              c1 = '0;
  logic [FPC_ACC_W-1:0]  acc0, acc1, lat0, lat1;
  int                    fails = 0;
  int                    samples_checked = 0;
  localparam int         ACC0 = 0;
  localparam int         ACC1 = 1;
  localparam int         LAT0 = 2;
  localparam int         LAT1 = 3;
  fpc_pulse_src src_u (.i_sys_clk(clk), .o_pulse(pulse));
  fpc_dual_counter #(.P_WIN_TICKS(20)) dut_u (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_pulse(pulse), .i_cfg_0(c0), .i_cfg_1(c1),
    .o_acc_0(acc0), .o_acc_1(acc1), .o_latch_0(lat0), .o_latch_1(lat1));
  initial begin
    forever #4 clk = ~clk;
  end
  // The output is picked after settling; a value argument would be frozen at the call.
  task automatic chk(input int which, input logic [FPC_ACC_W-1:0] exp);
    logic [FPC_ACC_W-1:0] got;
    repeat (6) @(negedge clk);
    case (which)
      ACC0:    got = acc0;
      ACC1:    got = acc1;
      LAT0:    got = lat0;
      default: got = lat1;
    endcase
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: output %0d got %h want %h", $time, which, got, exp);
    end
  endtask
  task automatic go();
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
  endtask
  task automatic done(input int n);
    $display("test %0d done", n);
    rst_n = 1'b0;
    c0 = '0;
    c1 = '0;
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    stop_test();
  end
  initial begin
    c0.in2_sel = 2'h1;
    c0.in2_en = 1'b1;
    c1.sub = FPC_SUB_B;
    c1.in1_sel = 2'h2;
    go();
    src_u.pulse(0, 3, 8);
    src_u.pulse(1, 2, 8);
    src_u.pulse(2, 2, 3);
    chk(ACC0, 32'h0000_0005);
    chk(ACC1, 32'hffff_fffe);
    done(1);
    c1.mode = FPC_MODE_QUAD;
    c1.in1_sel = 2'h2;
    c1.in2_sel = 2'h3;
    c1.in2_en = 1'b1;
    go();
    src_u.pulse(1, 1, 8);
    chk(ACC0, 32'h0000_0000);
    src_u.quad(8, 1'b1);
    chk(ACC1, 32'h0000_0008);
    src_u.quad(3, 1'b0);
    chk(ACC1, 32'h0000_0005);
    src_u.quad(3, 1'b1);
    chk(ACC1, 32'h0000_0008);
    done(2);
    c0.clr = '{1'b1, 2'h1, FPC_POL_FALL};
    c0.lat = '{1'b1, 2'h2, FPC_POL_RISE};
    c0.pre = '{1'b1, 2'h3, FPC_POL_RISE};
    c0.preload = 32'h0000_0100;
    c1.dis = '{1'b1, 2'h3, FPC_POL_LOW};
    go();
    src_u.pulse(0, 3, 8);
    src_u.pulse(2, 1, 8);
    chk(LAT0, 32'h0000_0003);
    src_u.pulse(0, 1, 8);
    chk(ACC0, 32'h0000_0004);
    chk(LAT0, 32'h0000_0003);
    chk(ACC1, 32'h0000_0000);
    src_u.pulse(3, 1, 8);
    chk(ACC0, 32'h0000_0100);
    src_u.pulse(1, 1, 8);
    chk(ACC0, 32'h0000_0000);
    done(3);
    c0.mode = FPC_MODE_PER;
    c0.clr = '{1'b1, 2'h1, FPC_POL_HIGH};
    c0.pre = '{1'b1, 2'h1, FPC_POL_HIGH};
    c0.preload = 32'h0000_0100;
    c1 = c0;
    c1.mode = FPC_MODE_WIDTH;
    go();
    src_u.set(1, 1'b1);
    src_u.pulse(0, 3, 125);
    chk(ACC0, 32'h0000_0002);
    chk(ACC1, 32'h0000_0000);
    src_u.set(1, 1'b0);
    done(4);
    c0.mode = FPC_MODE_FREQ;
    c0.pre = '{1'b1, 2'h3, FPC_POL_HIGH};
    c0.preload = 32'h0000_0100;
    c1.sub = FPC_SUB_C;
    c1.in1_sel = 2'h1;
    c1.in2_sel = 2'h2;
    c1.in2_en = 1'b1;
    c1.latch_on_release = 1'b1;
    c1.lat = '{1'b1, 2'h3, FPC_POL_HIGH};
    go();
    src_u.set(3, 1'b1);
    src_u.pulse(0, 10, 8);
    chk(ACC0, 32'h0000_0000);
    src_u.pulse(1, 3, 8);
    src_u.pulse(2, 1, 8);
    chk(LAT1, 32'h0000_0000);
    src_u.set(3, 1'b0);
    src_u.pulse(1, 1, 8);
    chk(ACC1, 32'h0000_0003);
    chk(LAT1, 32'h0000_0002);
    repeat (2300) @(negedge clk);
    chk(ACC0, 32'h0000_000a);
    done(5);
    stop_test();
  end
endmodule
`default_nettype wire
